// ==== buffered_pwm_compare_bank.sv ====
`timescale 1ns/1ns
// How it works
// - Compare-timer channels run mode 0, own output.
// - Latch equal reload keeps output constantly high.
// - Value 0FFF gives one-count high at end.
// - One timer count equals two clock periods.
// - Channels raise no interrupt of their own.
// - Register latch separate; only compare latch compares.
// - Mode 0 copies latch only on overflow.
// - Every overflow sets the overflow flag.
// - No low byte write, no overflow load.
// - High byte write alone never arms loading.
// - Low byte write arms full 16-bit load.
// - Mode 0 new values act only in next period.
// - Compare latch hidden from software entirely.
// - Timer 2 channels run compare mode 1.
// - Mode 1 low byte write loads immediately.
// - Select bit set: compare timer, else timer 2.
// - Enable bit routes the channel to output.
module buffered_pwm_compare_bank
  import pwm_cmp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [7:0]  regRdData,
  input  wire logic [15:0] t2Count,
  output logic      [7:0]  pwmOut,
  output logic             ctOverflow
);

  typedef struct packed {
    logic [15:0] count;
    logic        phase;
    logic [15:0] reload;
    logic [7:0]  srcSel;
    logic [7:0]  outEn;
    logic        run;
    logic        ovfFlag;
    logic [7:0]  rdData;
  } bank_s;

  bank_s state_r;
  bank_s state_nxt;

  logic        tick;
  logic        overflow;
  logic [7:0]  wrLow;
  logic [7:0]  wrHigh;
  logic [15:0] regLatch [NUM_CH];
  logic        chanWrite;

  // Each machine state spans OSC_PER_STATE clocks; the timer steps once per state.
  assign tick      = state_r.run && state_r.phase;
  assign overflow  = tick && (state_r.count >= CT_TOP);
  assign chanWrite = regWr && (regAddr <= ADDR_CH_LAST);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++)
    begin : g_chan
      assign wrLow[gi]  = chanWrite && (regAddr[3:1] == 3'(gi)) && !regAddr[0];
      assign wrHigh[gi] = chanWrite && (regAddr[3:1] == 3'(gi)) && regAddr[0];

      cmp_channel u_chan (
        .sys_clk     (sys_clk),
        .srst        (srst),
        .wrLow       (wrLow[gi]),
        .wrHigh      (wrHigh[gi]),
        .wrData      (regWrData),
        .useCmpTimer (state_r.srcSel[gi]),
        .outEnable   (state_r.outEn[gi]),
        .overflow    (overflow),
        .cmpCount    (state_r.count),
        .t2Count     (t2Count),
        .regLatch    (regLatch[gi]),
        .pwmOut      (pwmOut[gi])
      );
    end
  endgenerate

  always_comb
  begin
    state_nxt        = state_r;
    state_nxt.rdData = 8'h00;
    state_nxt.phase  = state_r.run ? (state_r.phase + 1'b1) : 1'b0;
    if (overflow)
    begin
      state_nxt.count = state_r.reload;
    end
    else if (tick)
    begin
      state_nxt.count = state_r.count + 16'h0001;
    end
    if (regWr)
    begin
      case (regAddr)
        ADDR_RELOAD_LO: state_nxt.reload[7:0]  = regWrData;
        ADDR_RELOAD_HI: state_nxt.reload[15:8] = regWrData;
        ADDR_SRC_SEL:   state_nxt.srcSel       = regWrData;
        ADDR_OUT_EN:    state_nxt.outEn        = regWrData;
        ADDR_CTRL:
        begin
          state_nxt.run = regWrData[CTRL_RUN_BIT];
          // Writing zero clears the flag; writing one leaves it alone.
          if (!regWrData[CTRL_OVF_BIT])
          begin
            state_nxt.ovfFlag = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // A fresh overflow beats a clear in the same cycle.
    if (overflow)
    begin
      state_nxt.ovfFlag = 1'b1;
    end
    if (regRd)
    begin
      if (regAddr <= ADDR_CH_LAST)
      begin
        state_nxt.rdData = regAddr[0] ? regLatch[regAddr[3:1]][15:8]
                                      : regLatch[regAddr[3:1]][7:0];
      end
      else
      begin
        case (regAddr)
          ADDR_RELOAD_LO: state_nxt.rdData = state_r.reload[7:0];
          ADDR_RELOAD_HI: state_nxt.rdData = state_r.reload[15:8];
          ADDR_SRC_SEL:   state_nxt.rdData = state_r.srcSel;
          ADDR_OUT_EN:    state_nxt.rdData = state_r.outEn;
          ADDR_CTRL:
          begin
            state_nxt.rdData[CTRL_RUN_BIT] = state_r.run;
            state_nxt.rdData[CTRL_OVF_BIT] = state_r.ovfFlag;
          end
          ADDR_COUNT_LO:  state_nxt.rdData = state_r.count[7:0];
          ADDR_COUNT_HI:  state_nxt.rdData = state_r.count[15:8];
          default:        state_nxt.rdData = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state_r <= '{RELOAD_RST, 1'b0, RELOAD_RST, SRC_SEL_RST, OUT_EN_RST,
                   1'b0, 1'b0, 8'h00};
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // The only event leaving the bank is the timer overflow; channels have none.
  assign regRdData  = state_r.rdData;
  assign ctOverflow = overflow;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  sequence sOverflow;
    overflow;
  endsequence

  a_ovf_sets_flag: assert property (
    sOverflow |=> state_r.ovfFlag)
    else $error("overflow did not set the flag");

  a_reload_restart: assert property (
    sOverflow |=> state_r.count == $past(state_r.reload))
    else $error("timer did not restart from reload");

  a_count_rate: assert property (
    (tick && !overflow) |=> !tick ##1 (state_r.count == $past(state_r.count, 2) + 16'h0001))
    else $error("timer count rate is not one per two clocks");

endmodule

// ==== buffered_pwm_compare_bank_tb.sv ====
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value at %0t: got %0h exp %0h", $time, a, b); end end
module buffered_pwm_compare_bank_tb
  import pwm_cmp_pkg::*;
;
  localparam logic [15:0] RLD = 16'h0F00;
  logic        sys_clk;
  logic        srst;
  logic [7:0]  regAddr;
  logic [7:0]  regWrData;
  logic        regWr;
  logic        regRd;
  logic [7:0]  regRdData;
  logic [15:0] t2Count;
  logic [7:0]  pwmOut;
  logic        ctOverflow;
  logic [15:0] hc [8];
  int          error_cnt = 0;
  int          num_checks = 0;

  buffered_pwm_compare_bank u_dut (.sys_clk(sys_clk), .srst(srst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .t2Count(t2Count), .pwmOut(pwmOut), .ctOverflow(ctOverflow));
  cpu_bus_model u_cpu (.sys_clk(sys_clk), .regRdData(regRdData), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd));

  // A count lasts two clocks, so a value v is high two clocks per count from v up to and including the top.
  function automatic logic [15:0] exp_high(input logic [15:0] v);
    return (CT_TOP + 16'h0001 - v) << 1;
  endfunction

  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Counts high clocks per channel over one whole period, optionally rewriting
  // channel 3 early in that period, well before its high window starts.
  // The window spans exactly one period, so it must hold exactly one overflow.
  task automatic meas(input logic w, input logic [7:0] lo);
    int i;
    int ch;
    logic [15:0] ov;
    while (ctOverflow !== 1'b1) @(negedge sys_clk);
    @(negedge sys_clk);
    `CHK(ctOverflow, 1'b0)
    @(negedge sys_clk);
    for (ch = 0; ch < 8; ch++) hc[ch] = 16'h0000;
    ov = 16'h0000;
    fork
      for (i = 0; i < int'(exp_high(RLD)); i++)
      begin
        for (ch = 0; ch < 8; ch++) hc[ch] += {15'h0000, pwmOut[ch]};
        ov += {15'h0000, ctOverflow};
        @(negedge sys_clk);
      end
      if (w)
      begin
        u_cpu.wr(8'h07, 8'h0F);
        u_cpu.wr(8'h06, lo);
      end
    join
    `CHK(ov, 16'h0001)
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  initial
  begin
    #(30000 * 100);
    error_cnt++;
    end_sim();
  end

  initial
  begin
    integer seed;
    logic [7:0] d;
    logic [7:0] r;
    logic [15:0] v;
    seed = 70187;
    srst = 1'b1;
    t2Count = 16'h0000;
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    @(negedge sys_clk);
    `CHK(pwmOut, 8'h00)
    `CHK(ctOverflow, 1'b0)
    u_cpu.rd(ADDR_SRC_SEL, d);
    `CHK(d, SRC_SEL_RST)
    u_cpu.wr(ADDR_COUNT_LO, 8'hA5);
    u_cpu.rd(ADDR_COUNT_LO, d);
    `CHK(d, 8'h00)
    u_cpu.rd(8'h3C, d);
    `CHK(d, 8'h00)
    u_cpu.wr(ADDR_OUT_EN, 8'h1F);
    v = {1'b0, 15'($random(seed))} | 16'h0001;
    u_cpu.wr16(3'h0, v);
    t2Count <= v - 16'h0001;
    repeat (2) @(negedge sys_clk);
    `CHK(pwmOut[0], 1'b0)
    @(posedge sys_clk);
    t2Count <= v;
    repeat (2) @(negedge sys_clk);
    `CHK(pwmOut[0], 1'b1)
    u_cpu.rd(8'h00, d);
    `CHK(d, v[7:0])
    u_cpu.wr16(3'h1, CT_TOP);
    u_cpu.wr16(3'h2, RLD);
    u_cpu.wr16(3'h3, CT_TOP);
    u_cpu.wr16(3'h4, CT_TOP);
    u_cpu.wr(ADDR_RELOAD_HI, RLD[15:8]);
    u_cpu.wr(ADDR_RELOAD_LO, RLD[7:0]);
    u_cpu.wr(ADDR_SRC_SEL, 8'h1E);
    u_cpu.wr(ADDR_CTRL, 8'h01);
    u_cpu.wr(8'h09, 8'h0E);
    meas(1'b0, 8'h00);
    `CHK(hc[1], exp_high(CT_TOP))
    `CHK(hc[2], exp_high(RLD))
    `CHK(hc[4], exp_high(CT_TOP))
    u_cpu.rd(ADDR_CTRL, d);
    `CHK(d[CTRL_OVF_BIT], 1'b1)
    u_cpu.wr(ADDR_CTRL, 8'h01);
    u_cpu.rd(ADDR_CTRL, d);
    `CHK(d[CTRL_OVF_BIT], 1'b0)
    r = 8'($random(seed));
    meas(1'b1, r);
    `CHK(hc[3], exp_high(CT_TOP))
    u_cpu.wr(ADDR_OUT_EN, 8'h0F);
    // A high byte alone after the load must not be picked up at the next overflow.
    u_cpu.wr(8'h07, 8'h0E);
    u_cpu.rd(8'h07, d);
    `CHK(d, 8'h0E)
    meas(1'b0, 8'h00);
    `CHK(hc[3], exp_high({RLD[15:8], r}))
    `CHK(hc[1], exp_high(CT_TOP))
    `CHK(hc[4], 16'h0000)
    end_sim();
  end
endmodule

// ==== cmp_channel.sv ====
`timescale 1ns/1ns
module cmp_channel
  import pwm_cmp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        wrLow,
  input  wire logic        wrHigh,
  input  wire logic [7:0]  wrData,
  input  wire logic        useCmpTimer,
  input  wire logic        outEnable,
  input  wire logic        overflow,
  input  wire logic [15:0] cmpCount,
  input  wire logic [15:0] t2Count,
  output logic      [15:0] regLatch,
  output logic             pwmOut
);

  typedef struct packed {
    logic [15:0] regLatch;
    logic [15:0] cmpLatch;
    logic        armed;
    logic        out;
  } chan_s;

  chan_s state_r;
  chan_s state_nxt;
  logic [15:0] timeBase;

  always_comb
  begin
    state_nxt = state_r;
    timeBase  = useCmpTimer ? cmpCount : t2Count;
    if (wrLow)
    begin
      state_nxt.regLatch[7:0] = wrData;
    end
    if (wrHigh)
    begin
      state_nxt.regLatch[15:8] = wrData;
    end
    if (useCmpTimer)
    begin
      // A low byte write that lands on the overflow stays armed for the next one.
      if (overflow && state_r.armed)
      begin
        state_nxt.cmpLatch = state_r.regLatch;
      end
      state_nxt.armed = wrLow || (state_r.armed && !overflow);
    end
    else
    begin
      if (wrLow)
      begin
        state_nxt.cmpLatch = {state_r.regLatch[15:8], wrData};
      end
      state_nxt.armed = 1'b0;
    end
    // Level is high from the match to the end of the period.
    state_nxt.out = outEnable && (timeBase >= state_r.cmpLatch);
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state_r <= '{LATCH_RST, LATCH_RST, 1'b0, 1'b0};
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // The compare latch is never visible here; software sees the register latch.
  assign regLatch = state_r.regLatch;
  assign pwmOut   = state_r.out;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  sequence sArmedOverflow;
    useCmpTimer && overflow && state_r.armed;
  endsequence

  a_ovf_load_value: assert property (
    sArmedOverflow |=> state_r.cmpLatch == $past(state_r.regLatch))
    else $error("armed overflow did not load compare latch");

  a_unarmed_no_load: assert property (
    (useCmpTimer && !state_r.armed) |=> $stable(state_r.cmpLatch))
    else $error("compare latch changed without an armed load");

  a_high_byte_no_arm: assert property (
    (useCmpTimer && wrHigh && !wrLow && !state_r.armed) |=> !state_r.armed)
    else $error("high byte write armed a load");

  a_period_protect: assert property (
    (useCmpTimer && !overflow) |=> $stable(state_r.cmpLatch))
    else $error("compare latch changed inside a period");

  a_direct_load: assert property (
    (!useCmpTimer && wrLow) |=> state_r.cmpLatch == {$past(state_r.regLatch[15:8]), $past(wrData)})
    else $error("low byte write did not load in mode 1");

  a_disabled_low: assert property (
    (!outEnable)[*2] |-> !pwmOut)
    else $error("disabled channel drives high");

endmodule

// ==== cpu_bus_model.sv ====
`timescale 1ns/1ns
module cpu_bus_model
(
  input  wire logic       sys_clk,
  input  wire logic [7:0] regRdData,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWrData,
  output logic            regWr,
  output logic            regRd
);
  initial
  begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(negedge sys_clk);
    d = regRdData;
  endtask

  // High byte first, since only the low byte write arms the 16-bit load.
  task automatic wr16(input logic [2:0] ch, input logic [15:0] v);
    wr({4'h0, ch, 1'b1}, v[15:8]);
    wr({4'h0, ch, 1'b0}, v[7:0]);
  endtask
endmodule

// ==== pwm_cmp_pkg.sv ====
package pwm_cmp_pkg;

  localparam int          NUM_CH          = 8;
  localparam int          DATA_W          = 16;

  // Register map, byte-wide registers on the plain register port.
  // Channel x low byte sits at 2*x and its high byte at 2*x+1.
  localparam logic [7:0]  ADDR_CH_LAST    = 8'h0F;
  localparam logic [7:0]  ADDR_RELOAD_LO  = 8'h10;
  localparam logic [7:0]  ADDR_RELOAD_HI  = 8'h11;
  localparam logic [7:0]  ADDR_SRC_SEL    = 8'h12;
  localparam logic [7:0]  ADDR_OUT_EN     = 8'h13;
  localparam logic [7:0]  ADDR_CTRL       = 8'h14;
  localparam logic [7:0]  ADDR_COUNT_LO   = 8'h15;
  localparam logic [7:0]  ADDR_COUNT_HI   = 8'h16;

  // Control register fields.
  localparam int          CTRL_RUN_BIT    = 0;
  localparam int          CTRL_OVF_BIT    = 7;

  // Reset values.
  localparam logic [15:0] RELOAD_RST      = 16'h0000;
  localparam logic [7:0]  SRC_SEL_RST     = 8'h00;
  localparam logic [7:0]  OUT_EN_RST      = 8'h00;
  localparam logic [15:0] LATCH_RST       = 16'h0000;

  // Compare timer top count; overflow happens on the step past it.
  localparam logic [15:0] CT_TOP          = 16'h0FFF;

  // One compare timer count lasts one machine state of two clock periods.
  localparam int          OSC_PER_STATE   = 2;

endpackage
